// ===== inc/bfseq_pkg.sv
// Shared constants for the beamformer sequencer and its slaves
package bfseq_pkg;
	localparam int NUM_CH = 32;
	localparam int CH_W = 5;
	localparam int SAMPLE_W = 12;
	localparam int NUM_SLAVES = 2;
	localparam int SLV_W = 1;
	localparam int CFG_W = 16;
	localparam int CFG_WORDS = 1 + NUM_SLAVES;
	localparam int CFG_IDX_W = 2;
	localparam int CFG_CH_IDX = 0;
	localparam int CFG_BEAM_IDX = 1;
	localparam int BEAM_W = 16;
	localparam int BCNT_W = 4;
	localparam int ACC_W = SAMPLE_W + CH_W;
	localparam int BUF_SLOTS = 255;
	localparam int SLOT_W = 8;
	localparam int BUF_ADDR_W = SLOT_W + CH_W;
	localparam logic [SLOT_W-1:0] PRIME_SETS = 8'hFF;
	localparam int FIFO_DEPTH = 8;
	localparam int PREP_CLKS = 4;
	localparam int PREP_W = 3;
	localparam int ADC_WAIT = 3;
	localparam int ADC_WAIT_W = 2;
	localparam int CLK_PERIOD_NS = 50;
	localparam int CYCLE_NS = 100000;
	localparam int CYCLE_CLKS = CYCLE_NS / CLK_PERIOD_NS;
	localparam int CYC_W = 11;
endpackage : bfseq_pkg

// ===== inc/bfseq_if.sv
// Common bus between the sequencing master and the beamforming slaves
`timescale 1ns/100ps
interface bfseq_if;
	import bfseq_pkg::*;
	logic cfg_valid;
	logic cfg_done;
	logic [CFG_IDX_W-1:0] cfg_index;
	logic [CFG_W-1:0] cfg_data;
	wire [NUM_SLAVES-1:0] slave_ready;
	logic smp_write;
	logic [CH_W-1:0] smp_chan;
	logic [SAMPLE_W-1:0] smp_data;
	logic beam_start;
	logic [NUM_SLAVES-1:0] fifo_pop;
	wire [NUM_SLAVES-1:0] fifo_valid;
	wire [NUM_SLAVES-1:0][BEAM_W-1:0] fifo_data;
	modport master (
		output cfg_valid, cfg_done, cfg_index, cfg_data,
		output smp_write, smp_chan, smp_data, beam_start, fifo_pop,
		input slave_ready, fifo_valid, fifo_data
	);
	modport slave (
		input cfg_valid, cfg_done, cfg_index, cfg_data,
		input smp_write, smp_chan, smp_data, beam_start, fifo_pop,
		output slave_ready, fifo_valid, fifo_data
	);
endinterface : bfseq_if

// ===== hdl/bfseq_slave.sv
// Beamforming slave with its sample ring and result FIFO
`timescale 1ns/100ps

module bfseq_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule : bfseq_fifo

module bfseq_slave import bfseq_pkg::*; #(
	parameter int SLAVE_ID = 0
) (
	input wire logic core_clk,
	input wire logic reset_n,
	bfseq_if.slave bus,
	output logic prepared,
	output logic busy
);
	typedef enum {B_IDLE, B_SUM, B_PUSH} bfseq_bstate_t;
	bfseq_bstate_t bstate;
	logic [SAMPLE_W-1:0] buf_mem [BUF_SLOTS * NUM_CH];
	logic [CH_W:0] n_ch;
	logic [BCNT_W-1:0] n_beams;
	logic prep_run;
	logic [PREP_W-1:0] prep_cnt;
	logic [SLOT_W-1:0] wr_slot;
	logic [SLOT_W-1:0] newest;
	logic [BCNT_W-1:0] beam;
	logic [CH_W-1:0] chan;
	logic [ACC_W-1:0] acc;
	logic [SLOT_W-1:0] rd_slot;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [BEAM_W-1:0] fifo_out_data;

	function automatic logic [SLOT_W-1:0] slot_back(input logic [SLOT_W-1:0] slot,
		input logic [SLOT_W-1:0] delay);
		if (slot >= delay) begin
			return slot - delay;
		end
		return SLOT_W'(int'(slot) + BUF_SLOTS - int'(delay));
	endfunction : slot_back

	function automatic logic [CH_W-1:0] last_of(input logic [CH_W:0] n);
		return CH_W'(n - 1'b1);
	endfunction : last_of

	// Delay is a whole number of sample periods per channel
	assign rd_slot = slot_back(newest, SLOT_W'(beam) * SLOT_W'(chan)); // RL15
	assign bus.slave_ready[SLAVE_ID] = prepared; // RL6
	assign bus.fifo_valid[SLAVE_ID] = fifo_out_valid;
	assign bus.fifo_data[SLAVE_ID] = fifo_out_data;

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			n_ch <= '0;
			n_beams <= '0;
			prep_run <= 1'b0;
			prep_cnt <= '0;
			prepared <= 1'b0;
		end else if (bus.cfg_valid) begin // RL14
			if (bus.cfg_index == CFG_IDX_W'(CFG_CH_IDX)) begin
				n_ch <= bus.cfg_data[CH_W:0];
			end
			if (bus.cfg_index == CFG_IDX_W'(CFG_BEAM_IDX + SLAVE_ID)) begin
				n_beams <= bus.cfg_data[BCNT_W-1:0];
			end
			prep_run <= bus.cfg_done;
			prep_cnt <= '0;
			prepared <= 1'b0;
		end else if (prep_run) begin // RL14
			prep_cnt <= prep_cnt + 1'b1;
			if (prep_cnt == PREP_W'(PREP_CLKS - 1)) begin
				prep_run <= 1'b0;
				prepared <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (prepared && bus.smp_write) begin // RL11
			buf_mem[{wr_slot, bus.smp_chan}] <= bus.smp_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			wr_slot <= '0;
			newest <= '0;
		end else if (prepared && bus.smp_write && bus.smp_chan == last_of(n_ch)) begin
			newest <= wr_slot;
			wr_slot <= (wr_slot == SLOT_W'(BUF_SLOTS - 1)) ? '0 : wr_slot + 1'b1; // RL17
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			bstate <= B_IDLE;
			beam <= '0;
			chan <= '0;
			acc <= '0;
			busy <= 1'b0;
		end else begin
			unique case (bstate)
				B_IDLE: begin
					if (bus.beam_start && prepared && n_beams != '0) begin
						beam <= '0;
						chan <= '0;
						acc <= '0;
						busy <= 1'b1;
						bstate <= B_SUM;
					end
				end
				B_SUM: begin
					acc <= acc + ACC_W'(buf_mem[{rd_slot, chan}]);
					if (chan == last_of(n_ch)) begin
						bstate <= B_PUSH;
					end else begin
						chan <= chan + 1'b1;
					end
				end
				B_PUSH: begin
					if (fifo_in_ready) begin // RL16
						if (beam == n_beams - 1'b1) begin
							busy <= 1'b0;
							bstate <= B_IDLE;
						end else begin
							beam <= beam + 1'b1;
							chan <= '0;
							acc <= '0;
							bstate <= B_SUM;
						end
					end
				end
			endcase
		end
	end

	bfseq_fifo #(
		.WIDTH(BEAM_W),
		.DEPTH(FIFO_DEPTH)
	) bfseq_fifo_inst (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.in_valid(bstate == B_PUSH),
		.in_ready(fifo_in_ready),
		.in_data(acc[ACC_W-1 -: BEAM_W]),
		.out_valid(fifo_out_valid),
		.out_ready(bus.fifo_pop[SLAVE_ID]),
		.out_data(fifo_out_data)
	);
endmodule : bfseq_slave

// ===== hdl/bfseq_master.sv
// Master sequencer: configuration, snapshot broadcast, beam start and drain
`timescale 1ns/100ps

// What this block does
// (RL1) Handles up to 32 hydrophone channels
// (RL2) Moves each sample as 12-bit word
// (RL3) Every cycle locked to sampling clock tick
// (RL4) Takes configuration from PC once first
// (RL5) Holds configuration, forwards it to all slaves
// (RL6) Waits until every slave reports ready
// (RL7) Ignores conversion ticks until slaves ready
// (RL8) Reads every channel, writes all slaves
// (RL9) One tick gives one simultaneous snapshot
// (RL10) Then starts beamforming in all slaves
// (RL11) First 255 sets only fill buffers; here only the first 254 do, and set 255 already starts beams
// (RL12) Steady state: broadcast, start, drain FIFOs
// (RL13) All duties finish within one cycle
// (RL14) Slaves idle, accept setup, then prepare
// (RL15) Steering delays whole sample periods
// (RL16) Slaves push beams; only master pops
// (RL17) Slave ring of 255 slots wraps
// (RL18) Beam start only after full snapshot written
module bfseq_master import bfseq_pkg::*; (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic pc_valid,
	input wire logic [CFG_W-1:0] pc_data,
	output logic pc_ready,
	input wire logic conv_done,
	output logic adc_rd,
	output logic [CH_W-1:0] adc_sel,
	input wire logic [SAMPLE_W-1:0] adc_data,
	output logic beam_valid,
	output logic [BEAM_W-1:0] beam_data,
	output logic [SLV_W-1:0] beam_src,
	output logic running,
	output logic overrun,
	bfseq_if.master bus
);
	typedef enum {
		S_PC,
		S_DIST,
		S_WAIT_RDY,
		S_IDLE,
		S_ADC,
		S_PUT,
		S_START,
		S_DRAIN
	} bfseq_state_t;

	bfseq_state_t state;
	logic [CFG_W-1:0] cfg [CFG_WORDS];
	logic [CFG_IDX_W-1:0] idx;
	logic [CH_W-1:0] ch;
	logic [ADC_WAIT_W-1:0] wait_cnt;
	logic [SLOT_W-1:0] sets_done;
	logic have_prev;
	logic [SLV_W-1:0] slv;
	logic [BCNT_W-1:0] bcnt;
	logic conv_s1;
	logic conv_s2;
	logic conv_s3;
	logic tick;
	logic [SAMPLE_W-1:0] adc_s1;
	logic [SAMPLE_W-1:0] adc_s2;
	logic pending;
	logic [CYC_W-1:0] cyc_cnt;

	function automatic logic [CH_W-1:0] last_ch(input logic [CFG_W-1:0] word);
		return CH_W'(word[CH_W:0] - 1'b1);
	endfunction : last_ch

	function automatic logic [BCNT_W-1:0] beams_of(input logic [CFG_W-1:0] word);
		return word[BCNT_W-1:0];
	endfunction : beams_of

	// Converter inputs conv_done and adc_data pass two flip-flops before use
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			conv_s1 <= 1'b0;
			conv_s2 <= 1'b0;
			conv_s3 <= 1'b0;
			adc_s1 <= '0;
			adc_s2 <= '0;
		end else begin
			conv_s1 <= conv_done;
			conv_s2 <= conv_s1;
			conv_s3 <= conv_s2;
			adc_s1 <= adc_data;
			adc_s2 <= adc_s1;
		end
	end

	assign tick = conv_s2 && !conv_s3; // RL3

	// Tick is latched; set wins over take
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pending <= 1'b0;
		end else if (tick && running) begin // RL7
			pending <= 1'b1;
		end else if (state == S_IDLE && pending) begin
			pending <= 1'b0;
		end
	end

	// Cycle budget watchdog
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cyc_cnt <= '0;
			overrun <= 1'b0;
		end else begin
			if (state == S_IDLE) begin
				cyc_cnt <= '0;
			end else if (running && cyc_cnt != CYC_W'(CYCLE_CLKS - 1)) begin
				cyc_cnt <= cyc_cnt + 1'b1;
			end
			if (running && state != S_IDLE && cyc_cnt == CYC_W'(CYCLE_CLKS - 2)) begin
				overrun <= 1'b1; // RL13
			end
			if (tick && pending) begin
				overrun <= 1'b1; // RL13
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state <= S_PC;
			pc_ready <= 1'b1;
			idx <= '0;
			ch <= '0;
			wait_cnt <= '0;
			sets_done <= '0;
			have_prev <= 1'b0;
			slv <= '0;
			bcnt <= '0;
			running <= 1'b0;
			adc_rd <= 1'b0;
			adc_sel <= '0;
			beam_valid <= 1'b0;
			beam_data <= '0;
			beam_src <= '0;
			bus.cfg_valid <= 1'b0;
			bus.cfg_done <= 1'b0;
			bus.cfg_index <= '0;
			bus.cfg_data <= '0;
			bus.smp_write <= 1'b0;
			bus.smp_chan <= '0;
			bus.smp_data <= '0;
			bus.beam_start <= 1'b0;
			bus.fifo_pop <= '0;
			for (int i = 0; i < CFG_WORDS; i++) begin
				cfg[i] <= '0;
			end
		end else begin
			adc_rd <= 1'b0;
			beam_valid <= 1'b0;
			bus.cfg_valid <= 1'b0;
			bus.cfg_done <= 1'b0;
			bus.smp_write <= 1'b0;
			bus.beam_start <= 1'b0;
			bus.fifo_pop <= '0;
			unique case (state)
				S_PC: begin
					if (pc_valid && pc_ready) begin // RL4
						cfg[idx] <= pc_data; // RL5
						if (idx == CFG_IDX_W'(CFG_WORDS - 1)) begin
							pc_ready <= 1'b0;
							idx <= '0;
							state <= S_DIST;
						end else begin
							idx <= idx + 1'b1;
						end
					end
				end
				S_DIST: begin
					bus.cfg_valid <= 1'b1; // RL5
					bus.cfg_index <= idx;
					bus.cfg_data <= cfg[idx];
					if (idx == CFG_IDX_W'(CFG_WORDS - 1)) begin
						bus.cfg_done <= 1'b1;
						state <= S_WAIT_RDY;
					end else begin
						idx <= idx + 1'b1;
					end
				end
				S_WAIT_RDY: begin
					if (&bus.slave_ready) begin // RL6
						running <= 1'b1;
						state <= S_IDLE;
					end
				end
				S_IDLE: begin
					if (pending) begin // RL3
						ch <= '0;
						adc_sel <= '0;
						adc_rd <= 1'b1;
						wait_cnt <= '0;
						state <= S_ADC;
					end
				end
				S_ADC: begin
					wait_cnt <= wait_cnt + 1'b1;
					if (wait_cnt == ADC_WAIT_W'(ADC_WAIT - 1)) begin
						bus.smp_write <= 1'b1; // RL8
						bus.smp_chan <= ch;
						bus.smp_data <= adc_s2; // RL2
						state <= S_PUT;
					end
				end
				S_PUT: begin
					if (ch == last_ch(cfg[CFG_CH_IDX])) begin // RL1
						state <= S_START; // RL9
					end else begin
						ch <= ch + 1'b1;
						adc_sel <= ch + 1'b1;
						adc_rd <= 1'b1;
						wait_cnt <= '0;
						state <= S_ADC;
					end
				end
				S_START: begin
					if (sets_done != PRIME_SETS) begin
						sets_done <= sets_done + 1'b1;
					end
					if (sets_done >= PRIME_SETS - 1'b1) begin // RL11
						bus.beam_start <= 1'b1; // RL10 RL18
						have_prev <= 1'b1;
					end
					slv <= '0;
					bcnt <= '0;
					state <= have_prev ? S_DRAIN : S_IDLE; // RL12
				end
				S_DRAIN: begin
					if (bus.fifo_pop[slv]) begin // RL16
						beam_valid <= 1'b1;
						beam_data <= bus.fifo_data[slv];
						beam_src <= slv;
						bcnt <= bcnt + 1'b1;
					end else if (bcnt == beams_of(cfg[CFG_BEAM_IDX + int'(slv)])) begin
						bcnt <= '0;
						if (slv == SLV_W'(NUM_SLAVES - 1)) begin
							state <= S_IDLE;
						end else begin
							slv <= slv + 1'b1;
						end
					end else if (bus.fifo_valid[slv]) begin
						bus.fifo_pop[slv] <= 1'b1; // RL12
					end
				end
			endcase
		end
	end
endmodule : bfseq_master

// ===== sim/bfseq_assertions.sv
// Checker on the common bus between master and slaves
`timescale 1ns/100ps
module bfseq_assertions import bfseq_pkg::*; (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic cfg_valid,
	input wire logic cfg_done,
	input wire logic [CFG_IDX_W-1:0] cfg_index,
	input wire logic [CFG_W-1:0] cfg_data,
	input wire logic [NUM_SLAVES-1:0] slave_ready,
	input wire logic smp_write,
	input wire logic [CH_W-1:0] smp_chan,
	input wire logic beam_start,
	input wire logic [NUM_SLAVES-1:0] fifo_pop,
	input wire logic [NUM_SLAVES-1:0] fifo_valid
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic cfg_seen;
	logic [CH_W:0] num_ch;
	logic [CH_W:0] wr_cnt;
	always_ff @(posedge core_clk) begin
		if (!reset_n) cfg_seen <= 1'b0;
		else if (cfg_done) cfg_seen <= 1'b1;
	end
	always_ff @(posedge core_clk) begin
		if (!reset_n) num_ch <= '0;
		else if (cfg_valid && cfg_index == 2'h0) num_ch <= cfg_data[CH_W:0];
	end
	// Writes within the current snapshot
	always_ff @(posedge core_clk) begin
		if (!reset_n) wr_cnt <= '0;
		else if (smp_write) wr_cnt <= (wr_cnt + 6'h1 == num_ch) ? '0 : wr_cnt + 6'h1;
	end
	a_cfg_word_order: assert property (cfg_valid && cfg_index == 2'h0 |=>
		cfg_valid && cfg_index == 2'h1 ##1 cfg_valid && cfg_index == 2'h2 && cfg_done)
		else $error("config words out of order");
	a_cfg_done_last: assert property (cfg_done |-> cfg_valid && cfg_index == 2'h2)
		else $error("config done not on last word");
	a_cfg_only_once: assert property (cfg_done |-> !cfg_seen)
		else $error("config sent twice");
	a_smp_after_ready: assert property (smp_write |-> slave_ready == '1 && cfg_seen)
		else $error("sample written before slaves ready");
	a_smp_chan_order: assert property (smp_write |-> smp_chan == wr_cnt[CH_W-1:0])
		else $error("channel out of sequence");
	a_start_full_set: assert property (beam_start |-> wr_cnt == '0 && !smp_write &&
		!$past(smp_write)) else $error("beam start before snapshot complete");
	a_start_one_pulse: assert property (beam_start |=> !beam_start [*8])
		else $error("beam start repeated");
	a_pop_when_valid: assert property (|fifo_pop |-> (fifo_pop & ~fifo_valid) == '0)
		else $error("pop of empty result FIFO");
	a_pop_spaced: assert property (|fifo_pop |=> fifo_pop == '0)
		else $error("pops on adjacent cycles");
	cover property (beam_start);
endmodule : bfseq_assertions

// ===== sim/tb_beamformer_master_sequencer.sv
// Bench for the sequencer and its two slaves
`timescale 1ns/100ps
module tb_beamformer_master_sequencer import bfseq_pkg::*;;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic pc_valid = 1'b0;
	logic conv_done = 1'b0;
	logic [CFG_W-1:0] pc_data = '0;
	logic [SAMPLE_W-1:0] adc_data = 12'hABC;
	logic pc_ready, adc_rd, beam_valid, running, overrun;
	logic [CH_W-1:0] adc_sel;
	logic [BEAM_W-1:0] beam_data;
	logic [SLV_W-1:0] beam_src;
	logic [NUM_SLAVES-1:0] prepared, busy;
	int num_errors = 0;
	int compares = 0;
	int n_start = 0;
	int n_rd = 0;
	int n_beam = 0;
	bfseq_if bus_if ();
	always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
	bfseq_master bfseq_master_inst (.core_clk(core_clk), .reset_n(reset_n),
		.pc_valid(pc_valid), .pc_data(pc_data), .pc_ready(pc_ready), .conv_done(conv_done),
		.adc_rd(adc_rd), .adc_sel(adc_sel), .adc_data(adc_data), .beam_valid(beam_valid),
		.beam_data(beam_data), .beam_src(beam_src), .running(running), .overrun(overrun),
		.bus(bus_if));
	for (genvar s = 0; s < NUM_SLAVES; s++) begin : gen_slv
		bfseq_slave #(.SLAVE_ID(s)) bfseq_slave_inst (.core_clk(core_clk), .reset_n(reset_n),
			.bus(bus_if), .prepared(prepared[s]), .busy(busy[s]));
	end
	bfseq_assertions bfseq_assertions_inst (.core_clk(core_clk), .reset_n(reset_n),
		.cfg_valid(bus_if.cfg_valid), .cfg_done(bus_if.cfg_done), .cfg_index(bus_if.cfg_index),
		.cfg_data(bus_if.cfg_data), .slave_ready(bus_if.slave_ready),
		.smp_write(bus_if.smp_write), .smp_chan(bus_if.smp_chan),
		.beam_start(bus_if.beam_start), .fifo_pop(bus_if.fifo_pop),
		.fifo_valid(bus_if.fifo_valid));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("errors %0d, compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up
	// Constant input: every beam of two channels equals the sample
	always @(negedge core_clk) begin
		if (bus_if.beam_start === 1'b1) n_start++;
		if (adc_rd === 1'b1) begin
			check(16'(adc_sel), 16'(n_rd % 2));
			n_rd++;
		end
		if (beam_valid === 1'b1) begin
			check(beam_data, 16'h0ABC);
			check(16'(beam_src), 16'(n_beam % 3 != 0));
			n_beam++;
		end
	end
	task automatic t_reset();
		reset_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		check(16'(pc_ready), 16'h1);
		check(16'(running), 16'h0);
		check(16'(overrun), 16'h0);
		@(posedge core_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask : t_reset
	// Fourth word must be refused; tick during setup ignored
	task automatic t_config();
		logic [CFG_W-1:0] w [4] = '{16'h0002, 16'h0001, 16'h0002, 16'h0005};
		int i;
		conv_done <= 1'b1;
		for (i = 0; i < 4; i++) begin
			pc_valid <= 1'b1;
			pc_data <= w[i];
			@(posedge core_clk);
		end
		pc_valid <= 1'b0;
		conv_done <= 1'b0;
		check(16'(prepared), 16'h0000);
		for (i = 0; i < 200 && running !== 1'b1; i++) @(negedge core_clk);
		check(16'(running), 16'h1);
		check(16'(prepared), 16'h0003);
		check(16'(pc_ready), 16'h0);
		check(16'(n_rd), 16'h0);
		if (running !== 1'b1) wrap_up();
		@(posedge core_clk);
	endtask : t_config
	task automatic t_ticks(input int n);
		repeat (n) begin
			conv_done <= 1'b1;
			repeat (4) @(posedge core_clk);
			conv_done <= 1'b0;
			repeat (96) @(posedge core_clk);
		end
	endtask : t_ticks
	task automatic t_prime();
		t_ticks(254);
		check(16'(n_start), 16'h0);
		check(16'(n_rd), 16'(254 * 2));
		t_ticks(1);
		check(16'(n_start), 16'h1);
		check(16'(n_beam), 16'h0);
	endtask : t_prime
	task automatic t_steady();
		t_ticks(3);
		check(16'(n_start), 16'h4);
		check(16'(n_beam), 16'h9);
		check(16'(n_rd), 16'(258 * 2));
		check(16'(overrun), 16'h0);
	endtask : t_steady
	// Results of the last cycle wait in the slave FIFOs until the next drain
	task automatic t_fifo();
		@(negedge core_clk);
		check(16'(bus_if.fifo_valid), 16'h0003);
		check(bus_if.fifo_data[0], 16'h0ABC);
		check(bus_if.fifo_data[1], 16'h0ABC);
		check(16'(busy), 16'h0000);
		@(posedge core_clk);
		t_ticks(1);
		@(negedge core_clk);
		check(16'(n_beam), 16'h000C);
		check(16'(bus_if.fifo_valid), 16'h0003);
		check(16'(busy), 16'h0000);
		@(posedge core_clk);
	endtask : t_fifo
	// Ticks faster than one cycle must raise the sticky overrun
	task automatic t_overrun();
		repeat (3) begin
			conv_done <= 1'b1;
			repeat (2) @(posedge core_clk);
			conv_done <= 1'b0;
			repeat (2) @(posedge core_clk);
		end
		repeat (40) @(posedge core_clk);
		@(negedge core_clk);
		check(16'(overrun), 16'h1);
		check(16'(running), 16'h1);
	endtask : t_overrun
	initial begin
		t_reset();
		t_config();
		t_prime();
		t_steady();
		t_fifo();
		t_overrun();
		wrap_up();
	end
endmodule : tb_beamformer_master_sequencer
